/* design/nsfr_params.svh */
// Constants for the nibble data space: addresses, fields, vectors, counts.
// Assumes a 6-bit direct address and 4-bit data nibbles.
`ifndef NSFR_PARAMS_SVH
`define NSFR_PARAMS_SVH

// Register addresses in the common block
`define NSFR_A_STATUS     6'h00
`define NSFR_A_DIR        6'h02
`define NSFR_A_PORT       6'h03
`define NSFR_A_SCR1       6'h07
`define NSFR_A_EXT        6'h08
`define NSFR_A_ACTRL      6'h09
`define NSFR_A_SLO        6'h0a
`define NSFR_A_SHI        6'h0b
`define NSFR_A_SCR2       6'h0f
`define NSFR_A_ROMP2      6'h1a

// Address space split
`define NSFR_SRAM_BIT     5
`define NSFR_BITOP_TOP    6'h0f
`define NSFR_SRAM_WORDS   64

// Status fields
`define NSFR_ST_IRQ       2
`define NSFR_ST_CARRY     1
`define NSFR_ST_ZERO      0

// Audio control fields
`define NSFR_AC_EN        0
`define NSFR_AC_GIE       1

// Reset values
`define NSFR_DIR_RST      4'h0
`define NSFR_NIB_RST      4'h0
`define NSFR_SAMPLE_RST   12'h000

// Program counter vectors and settle time
`define NSFR_VEC_RESET    12'h000
`define NSFR_VEC_WAKE     12'h004
`define NSFR_SETTLE_LAST  6'h3f
`define NSFR_CNT_ZERO     6'h00
`define NSFR_CNT_ONE      6'h01

`endif

/* design/nsfr_pkg.sv */
// Types shared by the nibble data space design.
// Assumes nsfr_params.svh for all numeric constants.
package nsfr_pkg;

  // Low-power sequencing states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_STOP,
    ST_SETTLE
  } nsfr_state_e;

  // Audio sample resolution chosen by option
  typedef enum logic [1:0] {
    W8,
    W10,
    W12
  } nsfr_width_e;

  // Everything the audio modulator needs
  typedef struct packed {
    logic        enable;
    logic        irq_enable;
    logic        pins_float;
    logic        sign;
    logic [11:0] sample;
  } nsfr_audio_s;

endpackage : nsfr_pkg

/* design/nsfr_edge_sync.sv */
// Two-flop synchroniser with rising-edge detect for the port pins.
// Assumes asynchronous pin levels and the already synchronised reset.
`timescale 1ns/10ps

module nsfr_edge_sync (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  // Pins in
  input  wire logic [3:0] i_pins,
  // Clean levels and rising edges
  output logic      [3:0] o_level,
  output logic      [3:0] o_rise
);

  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic [3:0] prev_q;

  ////////////////////////////////////////////////////////////////////////
  // Only sync_q reads meta_q; edges come from the second stage onward
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
      prev_q <= 4'h0;
    end else begin
      meta_q <= i_pins;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Level and edge taps
  assign o_level = sync_q;
  assign o_rise  = sync_q & ~prev_q;

endmodule : nsfr_edge_sync

/* design/nsfr_top.sv */
// Data space of a 4-bit controller: special registers, paged SRAM,
// port A and the stop / wake-up sequencer.
// Assumes the CPU core drives one access per cycle on the nibble port
// and does its own arithmetic; pins reach here unsynchronised.
//
// Function
// - One page bit selects which SRAM page answers upper addresses.
// - Page bit has no reset value; software loads it before SRAM use.
// - Addresses 00H-1FH always reach the register block.
// - Addresses 20H-3FH reach SRAM; contents undefined after reset.
// - Sixty-four SRAM nibbles in total over both pages.
// - Direct bit set/clear works only on 00H-0FH; indirect reaches all.
// - Registers read and write like SRAM for ALU instructions, except write-only 08H, 0AH, 0BH, which read as zero.
// - Status holds audio flag bit 2, carry bit 1, zero bit 0.
// - Direction bit 1 makes the pin output; resets to all inputs.
// - Port read returns pin levels; write sets the output latch.
// - Two scratch nibbles at 07H and 0FH outside the SRAM.
// - Extension nibble gives low sample bits in 10 and 12 bit modes.
// - Low nibble feeds sample bits per resolution mode.
// - High nibble is always the sample top; bit 3 is the sign.
// - Audio control bit 0 enables output, bit 1 enables interrupts.
// - Stop instruction halts program counter and system clock.
// - Rising edge on any port pin wakes from stop.
// - Stop loads vector 004; wake advances after 64 clocks.
// - Reset in stop wins: vector 000, advance after 64 clocks.
// - SRAM contents are kept through stop.
// - Mode change requests are ignored while stopped.
// - Audio flag sets when a modulation cycle completes.
// - Stop clears audio enable and floats the audio pins.
`timescale 1ns/10ps
`include "nsfr_params.svh"

module nsfr_top (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // Nibble access port
  input  wire logic [5:0]  i_addr,
  input  wire logic        i_rd_en,
  input  wire logic        i_wr_en,
  input  wire logic [3:0]  i_wr_data,
  output logic      [3:0]  o_rd_data,
  output logic             o_rd_valid,
  // Bit set / clear
  input  wire logic        i_bit_op,
  input  wire logic        i_bit_set,
  input  wire logic [1:0]  i_bit_sel,
  input  wire logic        i_indirect,
  // Page load and ALU flags
  input  wire logic        i_page_load,
  input  wire logic        i_page_val,
  input  wire logic        i_flag_we,
  input  wire logic        i_carry,
  input  wire logic        i_zero,
  // Audio
  input  wire logic        i_ten_bit_option,
  input  wire logic        i_twelve_bit_option,
  input  wire logic        i_audio_cycle_done,
  output nsfr_pkg::nsfr_audio_s o_audio,
  // Port A pins
  input  wire logic [3:0]  i_port_a_pins,
  output logic      [3:0]  o_port_a_pins,
  output logic      [3:0]  o_port_a_oe,
  // Stop and wake sequencing
  input  wire logic        i_stop_exec,
  input  wire logic        i_reset_req,
  input  wire logic        i_mode_change,
  output logic             o_mode_change_ok,
  output logic             o_clk_halt,
  output logic             o_pc_hold,
  output logic             o_pc_load,
  output logic      [11:0] o_pc_vector
);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Address lies in the SRAM half
  function automatic logic is_sram(input logic [5:0] a);
    is_sram = a[`NSFR_SRAM_BIT];
  endfunction : is_sram

  // Bit write of one nibble
  function automatic logic [3:0] bit_mod(input logic [3:0] v,
                                         input logic [1:0] s,
                                         input logic       set);
    logic [3:0] r;
    r    = v;
    r[s] = set;
    bit_mod = r;
  endfunction : bit_mod

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_m_q;
  logic rst_n_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Storage
  logic [3:0] sram_q [0:`NSFR_SRAM_WORDS-1];
  logic       page_q;
  logic [1:0] flags_q;      // carry, zero
  logic       irq_q;
  logic [3:0] dir_q;
  logic [3:0] latch_q;
  logic [3:0] scr1_q;
  logic [3:0] scr2_q;
  logic [3:0] romp2_q;
  logic [3:0] ext_q;
  logic [3:0] slo_q;
  logic [3:0] shi_q;
  logic       aen_q;
  logic       gie_q;
  nsfr_pkg::nsfr_state_e state_q;
  nsfr_pkg::nsfr_state_e state_d;
  logic [5:0] cnt_q;
  logic [3:0] pin_lvl;
  logic [3:0] pin_rise;

  // Pin synchroniser and wake edges
  nsfr_edge_sync u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (rst_n_q),
    .i_pins    (i_port_a_pins),
    .o_level   (pin_lvl),
    .o_rise    (pin_rise)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode; CPU is halted in stop, so accesses then are dropped
  logic       run;
  logic       bit_ok;
  logic       wr_fire;
  logic [5:0] sram_idx;
  logic [3:0] cur_val;
  logic [3:0] wr_val;
  logic [3:0] rd_val;

  assign run      = (state_q == nsfr_pkg::ST_RUN);
  assign bit_ok   = i_bit_op
                  & (i_indirect | (i_addr <= `NSFR_BITOP_TOP));
  assign wr_fire  = run & (i_wr_en | bit_ok);
  assign sram_idx = {page_q, i_addr[4:0]};

  // Internal value of the addressed nibble, write-only ones included
  always_comb begin
    cur_val = 4'h0;
    if (is_sram(i_addr)) begin
      cur_val = sram_q[sram_idx];
    end else begin
      unique case (i_addr)
        `NSFR_A_STATUS: cur_val = {1'b0, irq_q, flags_q};
        `NSFR_A_DIR:    cur_val = dir_q;
        `NSFR_A_PORT:   cur_val = pin_lvl;
        `NSFR_A_SCR1:   cur_val = scr1_q;
        `NSFR_A_EXT:    cur_val = ext_q;
        `NSFR_A_ACTRL:  cur_val = {2'b00, gie_q, aen_q};
        `NSFR_A_SLO:    cur_val = slo_q;
        `NSFR_A_SHI:    cur_val = shi_q;
        `NSFR_A_SCR2:   cur_val = scr2_q;
        `NSFR_A_ROMP2:  cur_val = romp2_q;
        default:        cur_val = 4'h0;
      endcase
    end
  end

  // Bit ops modify the current nibble; plain writes replace it
  assign wr_val = i_bit_op ? bit_mod(cur_val, i_bit_sel, i_bit_set)
                           : i_wr_data;

  // Write-only nibbles read back as zero
  assign rd_val = ((i_addr == `NSFR_A_EXT) | (i_addr == `NSFR_A_SLO)
                 | (i_addr == `NSFR_A_SHI)) ? 4'h0 : cur_val;

  ////////////////////////////////////////////////////////////////////////
  // SRAM and page bit carry no reset; contents are undefined until set
  always_ff @(posedge i_sys_clk) begin
    if (wr_fire && is_sram(i_addr)) begin
      sram_q[sram_idx] <= wr_val;
    end
    if (run && i_page_load) begin
      page_q <= i_page_val;
    end
  end

  // Scratch nibbles, undefined after reset
  always_ff @(posedge i_sys_clk) begin
    if (wr_fire && i_addr == `NSFR_A_SCR1) scr1_q <= wr_val;
    if (wr_fire && i_addr == `NSFR_A_SCR2) scr2_q <= wr_val;
    if (wr_fire && i_addr == `NSFR_A_ROMP2) romp2_q <= wr_val;
  end

  ////////////////////////////////////////////////////////////////////////
  // Status: ALU flags follow the bus write; audio event beats a clear
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_q   <= 1'b0;
      flags_q <= 2'b00;
    end else begin
      if (wr_fire && i_addr == `NSFR_A_STATUS) begin
        irq_q   <= wr_val[`NSFR_ST_IRQ];
        flags_q <= wr_val[`NSFR_ST_CARRY:`NSFR_ST_ZERO];
      end
      if (i_flag_we && run) begin
        flags_q <= {i_carry, i_zero};
      end
      if (i_audio_cycle_done) begin
        irq_q <= 1'b1;
      end
    end
  end

  // Port direction and output latch
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dir_q   <= `NSFR_DIR_RST;
      latch_q <= `NSFR_NIB_RST;
    end else begin
      if (wr_fire && i_addr == `NSFR_A_DIR) dir_q <= wr_val;
      if (wr_fire && i_addr == `NSFR_A_PORT) latch_q <= wr_val;
    end
  end

  // Sample nibbles are cleared so the modulator never sees unknowns
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ext_q <= `NSFR_NIB_RST;
      slo_q <= `NSFR_NIB_RST;
      shi_q <= `NSFR_NIB_RST;
    end else begin
      if (wr_fire && i_addr == `NSFR_A_EXT) ext_q <= wr_val;
      if (wr_fire && i_addr == `NSFR_A_SLO) slo_q <= wr_val;
      if (wr_fire && i_addr == `NSFR_A_SHI) shi_q <= wr_val;
    end
  end

  // Audio control; stop entry forces the enable off
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      aen_q <= 1'b0;
      gie_q <= 1'b0;
    end else if (run && i_stop_exec) begin
      aen_q <= 1'b0;
    end else if (wr_fire && i_addr == `NSFR_A_ACTRL) begin
      aen_q <= wr_val[`NSFR_AC_EN];
      gie_q <= wr_val[`NSFR_AC_GIE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sample assembly by resolution
  nsfr_pkg::nsfr_width_e width;
  logic [11:0]           sample_d;

  assign width = i_twelve_bit_option ? nsfr_pkg::W12
               : i_ten_bit_option    ? nsfr_pkg::W10 : nsfr_pkg::W8;

  always_comb begin
    unique case (width)
      nsfr_pkg::W8:  sample_d = {4'h0, shi_q, slo_q};
      nsfr_pkg::W10: sample_d = {2'b00, shi_q, slo_q, ext_q[3:2]};
      nsfr_pkg::W12: sample_d = {shi_q, slo_q, ext_q};
      default:       sample_d = `NSFR_SAMPLE_RST;
    endcase
  end

  // Registered audio carrier
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_audio <= '0;
    end else begin
      o_audio.enable     <= aen_q;
      o_audio.irq_enable <= gie_q;
      o_audio.pins_float <= (state_q != nsfr_pkg::ST_RUN);
      o_audio.sign       <= shi_q[3];
      o_audio.sample     <= sample_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stop / wake sequencer; a reset request always outranks a wake edge
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      nsfr_pkg::ST_RUN: begin
        if (i_reset_req) state_d = nsfr_pkg::ST_SETTLE;
        else if (i_stop_exec) state_d = nsfr_pkg::ST_STOP;
      end
      nsfr_pkg::ST_STOP: begin
        if (i_reset_req) state_d = nsfr_pkg::ST_SETTLE;
        else if (|pin_rise) state_d = nsfr_pkg::ST_SETTLE;
      end
      nsfr_pkg::ST_SETTLE: begin
        if (!i_reset_req && cnt_q == `NSFR_SETTLE_LAST) begin
          state_d = nsfr_pkg::ST_RUN;
        end
      end
    endcase
  end

  // State, settle count and vector load
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q     <= nsfr_pkg::ST_SETTLE;
      cnt_q       <= `NSFR_CNT_ZERO;
      o_pc_load   <= 1'b1;
      o_pc_vector <= `NSFR_VEC_RESET;
    end else begin
      state_q   <= state_d;
      o_pc_load <= 1'b0;
      if (i_reset_req) begin
        cnt_q       <= `NSFR_CNT_ZERO;
        o_pc_load   <= 1'b1;
        o_pc_vector <= `NSFR_VEC_RESET;
      end else if (run && i_stop_exec) begin
        cnt_q       <= `NSFR_CNT_ZERO;
        o_pc_load   <= 1'b1;
        o_pc_vector <= `NSFR_VEC_WAKE;
      end else if (state_q == nsfr_pkg::ST_SETTLE) begin
        cnt_q <= cnt_q + `NSFR_CNT_ONE;
      end
    end
  end

  // Read port; data from flops, one cycle after the request
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_rd_data  <= `NSFR_NIB_RST;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= run & i_rd_en;
      if (run && i_rd_en) o_rd_data <= rd_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_port_a_pins    = latch_q;
  assign o_port_a_oe      = dir_q;
  assign o_pc_hold        = !run;
  assign o_clk_halt       = (state_q == nsfr_pkg::ST_STOP);
  assign o_mode_change_ok = run & i_mode_change;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_stop_taken;
    run && i_stop_exec && !i_reset_req;
  endsequence

  sequence s_vector_wake;
    o_pc_load && o_pc_vector == 12'h004 && o_clk_halt;
  endsequence

  chk_stop_vector: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    s_stop_taken |=> s_vector_wake)
    else $error("stop entry did not load wake vector");

  chk_settle_count: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    (state_q == nsfr_pkg::ST_SETTLE && state_d == nsfr_pkg::ST_RUN)
      |-> cnt_q == 6'd63)
    else $error("settle left before 64 cycles");

  chk_reset_prio: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    (o_clk_halt && i_reset_req) |=>
      (o_pc_load && o_pc_vector == 12'h000 && !o_clk_halt
       && o_pc_hold && cnt_q == 6'd0))
    else $error("reset in stop not taken first");

  chk_wake_edge: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    (o_clk_halt && |pin_rise && !i_reset_req) |=>
      (!o_clk_halt && o_pc_hold && !o_pc_load) [*2])
    else $error("wake edge not followed by settle");

  chk_irq_set: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    i_audio_cycle_done |=> irq_q)
    else $error("audio flag not set");

  chk_stop_audio: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    s_stop_taken |=> !aen_q ##1 (o_audio.pins_float && !o_audio.enable))
    else $error("stop left audio enabled");

  chk_mode_blocked: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    o_pc_hold |-> !o_mode_change_ok)
    else $error("mode change accepted while halted");

  chk_dir_write: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    (run && i_wr_en && !i_bit_op && i_addr == 6'h02)
      |=> o_port_a_oe == $past(i_wr_data))
    else $error("direction write lost");

  chk_sample_top: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    (run && i_wr_en && !i_bit_op && i_addr == 6'h0b)
      |-> ##2 (o_audio.sample[11:8] == $past(i_wr_data, 2)
               || !i_twelve_bit_option)
          && o_audio.sign == $past(i_wr_data[3], 2))
    else $error("sample top nibble wrong");

  chk_bitop_range: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    (run && i_bit_op && !i_wr_en && !i_indirect && i_addr == 6'h1a)
      |=> $stable(romp2_q))
    else $error("direct bit op reached upper block");

  chk_page_sel: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    (run && i_page_load) |=> page_q == $past(i_page_val))
    else $error("page bit not loaded");

endmodule : nsfr_top

/* dv/tb.sv */
// Self-checking bench for the nibble data space top.
// Assumes nsfr_pkg and nsfr_top are compiled first; drives every port.
`timescale 1ns/10ps

module tb;
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [5:0] a;
    logic [3:0] w;
    logic [3:0] e;
    logic [3:0] m;
  } nsfr_row_s;

  logic       clk = 1'h0;
  logic       rst_n = 1'h0;
  logic [5:0] ad = 6'h00;
  logic [3:0] wd = 4'h0;
  logic [3:0] pins = 4'h0;
  logic [1:0] bsel = 2'h0;
  logic       rd = 1'h0, wr = 1'h0, bop = 1'h0, bset = 1'h0, ind = 1'h0;
  logic       pl = 1'h0, pv = 1'h0, fwe = 1'h0, cy = 1'h0, zr = 1'h0;
  logic       o10 = 1'h0, o12 = 1'h0, adone = 1'h0, stp = 1'h0;
  logic       rreq = 1'h0, mchg = 1'h0;
  logic [3:0] rdat, pout, oe, q;
  logic       rval, mok, halt, hold, pload;
  logic [11:0] vec;
  nsfr_pkg::nsfr_audio_s aud;
  int         errors = 0;
  int         n_checks = 0;
  int         n;

  // Ordinary cases: write a value, read back under a mask
  nsfr_row_s rows [10] = '{
    '{6'h07, 4'h5, 4'h5, 4'hf}, '{6'h0f, 4'ha, 4'ha, 4'hf},
    '{6'h1a, 4'h3, 4'h3, 4'hf}, '{6'h02, 4'hc, 4'hc, 4'hf},
    '{6'h09, 4'h2, 4'h2, 4'h3}, '{6'h01, 4'hf, 4'h0, 4'hf},
    '{6'h0c, 4'hf, 4'h0, 4'hf}, '{6'h08, 4'hf, 4'h0, 4'hf},
    '{6'h0a, 4'hf, 4'h0, 4'hf}, '{6'h3f, 4'h6, 4'h6, 4'hf}};

  // Sample layout per option pair: ten, twelve, expected sample
  logic [13:0] modes [4] = '{{2'h0, 12'h0a6}, {2'h2, 12'h29b},
                             {2'h1, 12'ha6d}, {2'h3, 12'ha6d}};

  always #5 clk = ~clk;

  nsfr_top DUT (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_addr(ad), .i_rd_en(rd),
    .i_wr_en(wr), .i_wr_data(wd), .o_rd_data(rdat), .o_rd_valid(rval),
    .i_bit_op(bop), .i_bit_set(bset), .i_bit_sel(bsel), .i_indirect(ind),
    .i_page_load(pl), .i_page_val(pv), .i_flag_we(fwe), .i_carry(cy),
    .i_zero(zr), .i_ten_bit_option(o10), .i_twelve_bit_option(o12),
    .i_audio_cycle_done(adone), .o_audio(aud), .i_port_a_pins(pins),
    .o_port_a_pins(pout), .o_port_a_oe(oe), .i_stop_exec(stp),
    .i_reset_req(rreq), .i_mode_change(mchg), .o_mode_change_ok(mok),
    .o_clk_halt(halt), .o_pc_hold(hold), .o_pc_load(pload),
    .o_pc_vector(vec));

  ////////////////////////////////////////////////////////////////////////
  // Comparisons, one per kind of result
  task automatic bad(input string m);
    errors++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask : bad

  task automatic cmp_nib(input logic [3:0] g, e, k, input string m);
    n_checks++;
    if ((g & k) !== (e & k)) bad(m);
  endtask : cmp_nib

  task automatic cmp_bit(input logic g, e, input string m);
    n_checks++;
    if (g !== e) bad(m);
  endtask : cmp_bit

  task automatic cmp_word(input logic [11:0] g, e, input string m);
    n_checks++;
    if (g !== e) bad(m);
  endtask : cmp_word

  // Bus cycles: request held one edge, then dropped
  task automatic wrn(input logic [5:0] a, input logic [3:0] d);
    @(posedge clk);
    ad <= a;
    wd <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wrn

  task automatic rdn(input logic [5:0] a, output logic [3:0] r);
    @(posedge clk);
    ad <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    cmp_bit(rval, 1'h1, "read valid");
    r = rdat;
  endtask : rdn

  task automatic bitop(input logic [5:0] a, input logic [1:0] s,
                       input logic st, id);
    @(posedge clk);
    ad <= a;
    bsel <= s;
    bset <= st;
    ind <= id;
    bop <= 1'h1;
    @(posedge clk);
    bop <= 1'h0;
  endtask : bitop

  task automatic page(input logic v);
    @(posedge clk);
    pv <= v;
    pl <= 1'h1;
    @(posedge clk);
    pl <= 1'h0;
  endtask : page

  // Bounded wait for the program counter to run again
  task automatic settle(output int c);
    c = 0;
    while (hold !== 1'h0 && c < 200) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask : settle

  // Stop entry; a mode change request rides along
  task automatic stop_now;
    @(posedge clk);
    stp <= 1'h1;
    mchg <= 1'h1;
    #1;
    cmp_bit(mok, 1'h1, "mode change in run");
    @(posedge clk);
    stp <= 1'h0;
    #1;
    cmp_bit(pload, 1'h1, "stop load");
    cmp_word(vec, 12'h004, "stop vector");
    cmp_bit(halt, 1'h1, "clock halt");
    cmp_bit(mok, 1'h0, "mode change in stop");
    @(posedge clk);
    mchg <= 1'h0;
    #1;
    cmp_bit(aud.enable, 1'h0, "audio off");
    cmp_bit(aud.pins_float, 1'h1, "audio float");
  endtask : stop_now

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////
  // Watchdog: the run needs a few hundred cycles at most
  initial begin
    #200000;
    bad("timeout");
    close_out();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    #1;
    cmp_nib(oe, 4'h0, 4'hf, "reset dir");
    cmp_word(vec, 12'h000, "reset vector");
    @(posedge clk);
    rst_n <= 1'h1;
    settle(n);
    rdn(6'h00, q);
    cmp_nib(q, 4'h0, 4'hc, "status reset");
    page(1'h0);
    foreach (rows[i]) wrn(rows[i].a, rows[i].w);
    // Second pass also shows reserved writes touched nothing
    foreach (rows[i]) begin
      rdn(rows[i].a, q);
      cmp_nib(q, rows[i].e, rows[i].m, "row");
    end
    cmp_nib(oe, 4'hc, 4'hf, "dir to oe");
    // Paging: same address, two pages; common block is not paged
    wrn(6'h20, 4'ha);
    page(1'h1);
    wrn(6'h20, 4'h5);
    wrn(6'h1a, 4'h9);
    rdn(6'h20, q);
    cmp_nib(q, 4'h5, 4'hf, "page one");
    page(1'h0);
    rdn(6'h20, q);
    cmp_nib(q, 4'ha, 4'hf, "page zero");
    rdn(6'h1a, q);
    cmp_nib(q, 4'h9, 4'hf, "common block");
    // Port A latch, pin read; bit ops modify the synced pin levels
    wrn(6'h02, 4'hf);
    pins <= 4'h9;
    wrn(6'h03, 4'h5);
    #1;
    cmp_nib(pout, 4'h5, 4'hf, "latch write");
    bitop(6'h03, 2'h0, 1'h0, 1'h0);
    #1;
    cmp_nib(pout, 4'h8, 4'hf, "latch bit clear");
    bitop(6'h03, 2'h1, 1'h1, 1'h0);
    #1;
    cmp_nib(pout, 4'hb, 4'hf, "latch bit set");
    rdn(6'h03, q);
    cmp_nib(q, 4'h9, 4'hf, "pin levels");
    wrn(6'h1a, 4'h0);
    bitop(6'h1a, 2'h0, 1'h1, 1'h0);
    rdn(6'h1a, q);
    cmp_nib(q, 4'h0, 4'hf, "direct bit op high");
    bitop(6'h1a, 2'h0, 1'h1, 1'h1);
    rdn(6'h1a, q);
    cmp_nib(q, 4'h1, 4'hf, "indirect bit op");
    // Status: ALU flags, then flag set beats a clearing write
    @(posedge clk);
    cy <= 1'h1;
    fwe <= 1'h1;
    @(posedge clk);
    fwe <= 1'h0;
    rdn(6'h00, q);
    cmp_nib(q, 4'h2, 4'h3, "alu flags");
    wrn(6'h00, 4'h0);
    rdn(6'h00, q);
    cmp_nib(q, 4'h0, 4'h7, "status write");
    @(posedge clk);
    ad <= 6'h00;
    wd <= 4'h0;
    wr <= 1'h1;
    adone <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    adone <= 1'h0;
    rdn(6'h00, q);
    cmp_nib(q, 4'h4, 4'h4, "audio flag");
    // Audio sample assembly in every resolution
    wrn(6'h08, 4'hd);
    wrn(6'h0a, 4'h6);
    wrn(6'h0b, 4'ha);
    wrn(6'h09, 4'h1);
    foreach (modes[i]) begin
      @(posedge clk);
      {o10, o12} <= modes[i][13:12];
      repeat (3) @(posedge clk);
      #1;
      cmp_word(aud.sample, modes[i][11:0], "sample");
    end
    cmp_bit(aud.sign, 1'h1, "sign");
    cmp_bit(aud.enable, 1'h1, "audio on");
    cmp_bit(aud.irq_enable, 1'h0, "irq enable");
    // Stop, a dropped write, wake on a pin rise, 64-cycle settle
    @(posedge clk);
    pins <= 4'h0;
    repeat (3) @(posedge clk);
    stop_now();
    wrn(6'h20, 4'h0);
    @(posedge clk);
    pins <= 4'h2;
    n = 0;
    while (halt !== 1'h0 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp_bit(halt, 1'h0, "wake");
    settle(n);
    cmp_word(12'(n), 12'h040, "wake settle");
    rdn(6'h20, q);
    cmp_nib(q, 4'ha, 4'hf, "sram kept");
    rdn(6'h3f, q);
    cmp_nib(q, 4'h6, 4'hf, "sram kept");
    // Reset request while stopped loads the reset vector
    stop_now();
    repeat (3) @(posedge clk);
    rreq <= 1'h1;
    @(posedge clk);
    rreq <= 1'h0;
    #1;
    cmp_bit(pload, 1'h1, "reset load");
    cmp_word(vec, 12'h000, "reset vector");
    settle(n);
    cmp_word(12'(n), 12'h040, "reset settle");
    close_out();
  end
endmodule : tb
